// >>> hdl/mcu_interrupt_controller.v
// Interrupt controller: event flags, enables, global enable and fetch redirect
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.vh"

// What this block does
// - Software interrupt jumps to 0x001, clears global enable
// - Enable/disable instructions set/clear global enable
// - Return instruction sets global enable, resumes
// - Events set flags; only firmware zero clears
// - Flag reads zero unless its enable set
// - Enabled pending flag jumps 0x008, clears global
// - Exactly eleven hardware sources accepted
// - Timer zero wrap sets timer-zero flag
// - Ten-bit counter underflows set own flags
// - Watchdog interrupt mode expiry sets bit 6
// - Watchdog request needs its enable and global
// - Enabled input pin change sets shared flag
// - External select disables pin level-change
// - Selected edge on pin zero sets flag
// - Selected edge on pin one sets flag
// - Falling low-voltage signal sets its flag
// - Comparator mismatch interrupts; control read resyncs copy
// - Conversion end pulse sets converter flag
// - Enable instruction in handler allows nesting
module mcu_interrupt_controller (
  // Clock and reset
  input  wire                         clk_sys_i,
  input  wire                         resetn_i,
  // Instruction decode strobes from the sequencer (one cycle each; software held until ready)
  input  wire                         sw_irq_instr_i,
  input  wire                         enable_irq_instr_i,
  input  wire                         disable_irq_instr_i,
  input  wire                         return_from_irq_instr_i,
  input  wire                         fetch_ready_i,
  // Firmware access to flag and enable registers
  input  wire                         flag_wr_i,
  input  wire [`IRQ_NUM_SRC-1:0]      flag_wdata_i,
  input  wire                         enable_wr_i,
  input  wire [`IRQ_NUM_SRC-1:0]      enable_wdata_i,
  input  wire                         osc_comparator_ctrl_rd_i,
  // Timer events
  input  wire                         timer_zero_wrap_i,
  input  wire                         timer_one_underflow_i,
  input  wire                         timer_two_underflow_i,
  input  wire                         timer_three_underflow_i,
  // Watchdog
  input  wire                         watchdog_expire_i,
  input  wire                         watchdog_irq_mode_i,
  // Port pins and configuration
  input  wire [`IRQ_PORTA_WIDTH-1:0]  porta_pins_i,
  input  wire [`IRQ_PORTB_WIDTH-1:0]  portb_pins_i,
  input  wire [`IRQ_PORTA_WIDTH-1:0]  porta_is_input_i,
  input  wire [`IRQ_PORTB_WIDTH-1:0]  portb_is_input_i,
  input  wire [`IRQ_PORTA_WIDTH-1:0]  porta_wake_en_i,
  input  wire [`IRQ_PORTB_WIDTH-1:0]  portb_wake_en_i,
  input  wire                         ext_zero_select_i,
  input  wire                         ext_one_select_i,
  input  wire                         ext_edge_polarity_i,
  // Analog events
  input  wire                         low_voltage_detect_i,
  input  wire                         comparator_out_i,
  input  wire                         conv_end_i,
  // Firmware view
  output reg  [`IRQ_NUM_SRC-1:0]      irq_flag_rd_o,
  output reg  [`IRQ_NUM_SRC-1:0]      irq_enable_reg_o,
  output reg                          global_irq_enable_o,
  output reg                          comparator_copy_o,
  // Fetch redirect
  output wire                         vector_take_o,
  output reg  [`IRQ_PC_WIDTH-1:0]     vector_addr_o,
  output reg                          in_service_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [`IRQ_NUM_SRC-1:0] irq_flag_reg;      // Sticky flags
  reg  [`IRQ_NUM_SRC-1:0] irq_flag_next;     // Flag next value
  reg  [`IRQ_NUM_SRC-1:0] irq_enable_next;   // Enable next value
  reg                     gie_next;          // Global enable next value
  reg                     comp_copy_next;    // Comparator copy next value
  reg                     in_service_next;   // Handler-active next value
  reg  [`IRQ_NUM_SRC-1:0] event_vec;         // This cycle's raw events
  wire                    pin_change;        // Level change event
  wire                    pb0_rise;          // Port B pin 0 rising
  wire                    pb0_fall;          // Port B pin 0 falling
  wire                    pb1_rise;          // Port B pin 1 rising
  wire                    pb1_fall;          // Port B pin 1 falling
  wire                    lvd_fall;          // Low-voltage high-to-low
  wire                    ext0_edge;         // Selected edge on pin 0
  wire                    ext1_edge;         // Selected edge on pin 1
  wire                    hw_pending;        // Enabled flag pending
  wire                    hw_take;           // Hardware vector taken now
  wire                    sw_take;           // Software vector taken now

  // ----------------------------------------------------------------
  // Event detectors
  // ----------------------------------------------------------------
  pin_change_detect u_pin_change (
    .clk_sys_i         (clk_sys_i),
    .resetn_i          (resetn_i),
    .porta_pins_i      (porta_pins_i),
    .portb_pins_i      (portb_pins_i),
    .porta_is_input_i  (porta_is_input_i),
    .portb_is_input_i  (portb_is_input_i),
    .porta_wake_en_i   (porta_wake_en_i),
    .portb_wake_en_i   (portb_wake_en_i),
    .ext_zero_select_i (ext_zero_select_i),
    .ext_one_select_i  (ext_one_select_i),
    .change_o          (pin_change)
  );

  edge_event_detect u_edge_pb0 (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .level_i   (portb_pins_i[0]),
    .rise_o    (pb0_rise),
    .fall_o    (pb0_fall)
  );

  edge_event_detect u_edge_pb1 (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .level_i   (portb_pins_i[1]),
    .rise_o    (pb1_rise),
    .fall_o    (pb1_fall)
  );

  edge_event_detect u_edge_lvd (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .level_i   (low_voltage_detect_i),
    .rise_o    (),
    .fall_o    (lvd_fall)
  );

  // Polarity high picks rising edges, low picks falling edges
  assign ext0_edge = ext_zero_select_i &
                     (ext_edge_polarity_i ? pb0_rise : pb0_fall);
  assign ext1_edge = ext_one_select_i &
                     (ext_edge_polarity_i ? pb1_rise : pb1_fall);

  // ----------------------------------------------------------------
  // Event gathering
  // ----------------------------------------------------------------
  // One bit per source; exactly eleven inputs map into the flag word
  always @* begin
    event_vec = `IRQ_FLAG_RESET;
    event_vec[`IRQ_BIT_TIMER0] = timer_zero_wrap_i;
    event_vec[`IRQ_BIT_TIMER1] = timer_one_underflow_i;
    event_vec[`IRQ_BIT_TIMER2] = timer_two_underflow_i;
    event_vec[`IRQ_BIT_TIMER3] = timer_three_underflow_i;
    event_vec[`IRQ_BIT_PINCHG] = pin_change;
    event_vec[`IRQ_BIT_EXT0]   = ext0_edge;
    // Reset-mode watchdog expiry is handled elsewhere, not flagged here
    event_vec[`IRQ_BIT_WDOG]   = watchdog_expire_i & watchdog_irq_mode_i;
    event_vec[`IRQ_BIT_EXT1]   = ext1_edge;
    event_vec[`IRQ_BIT_LVD]    = lvd_fall;
    // Mismatch against the copy stays asserted until the control read
    event_vec[`IRQ_BIT_CMP]    = comparator_out_i ^ comparator_copy_o;
    event_vec[`IRQ_BIT_CONV]   = conv_end_i;
  end

  // ----------------------------------------------------------------
  // Vector decision
  // ----------------------------------------------------------------
  // All sources share one vector; software polls flags to find causes
  assign hw_pending = |(irq_flag_reg & irq_enable_reg_o);
  // Software interrupt ignores the global enable
  assign sw_take    = sw_irq_instr_i & fetch_ready_i;
  // Hardware vector only while global enable is set; software wins a tie
  assign hw_take    = hw_pending & global_irq_enable_o & fetch_ready_i &
                      ~sw_irq_instr_i;
  assign vector_take_o = sw_take | hw_take;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Flags: firmware write clears, new events set; set wins over clear
  always @* begin
    irq_flag_next = irq_flag_reg;
    if (flag_wr_i) begin
      irq_flag_next = irq_flag_reg & flag_wdata_i;
    end
    irq_flag_next = irq_flag_next | event_vec;
  end

  // Enables are plain firmware storage
  always @* begin
    irq_enable_next = irq_enable_reg_o;
    if (enable_wr_i) begin
      irq_enable_next = enable_wdata_i;
    end
  end

  // Global enable: vector entry clears it; instructions set or clear it
  always @* begin
    gie_next = global_irq_enable_o;
    if (sw_take | hw_take) begin
      gie_next = 1'b0;
    end else if (disable_irq_instr_i) begin
      gie_next = 1'b0;
    end else if (enable_irq_instr_i) begin
      // Also the nesting path when used first in a handler
      gie_next = 1'b1;
    end else if (return_from_irq_instr_i) begin
      gie_next = 1'b1;
    end
  end

  // Handler-active marker; a stray enable before return is software's
  // problem, the return still ends the handler here
  always @* begin
    in_service_next = in_service_o;
    if (sw_take | hw_take) begin
      in_service_next = 1'b1;
    end else if (return_from_irq_instr_i) begin
      in_service_next = 1'b0;
    end
  end

  // Reading the control register resynchronises the comparator copy
  always @* begin
    comp_copy_next = comparator_copy_o;
    if (osc_comparator_ctrl_rd_i) begin
      comp_copy_next = comparator_out_i;
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  // All control state has a constant reset value
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_flag_reg        <= `IRQ_FLAG_RESET;
      irq_enable_reg_o    <= `IRQ_EN_RESET;
      global_irq_enable_o <= `IRQ_GIE_RESET;
      comparator_copy_o   <= 1'b0;
      in_service_o        <= 1'b0;
    end else begin
      irq_flag_reg        <= irq_flag_next;
      irq_enable_reg_o    <= irq_enable_next;
      global_irq_enable_o <= gie_next;
      comparator_copy_o   <= comp_copy_next;
      in_service_o        <= in_service_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs from flops
  // ----------------------------------------------------------------
  // Read view masks disabled sources; vector address is registered from
  // the same-cycle software strobe, so it is valid the cycle after vector_take_o
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_flag_rd_o <= `IRQ_FLAG_RESET;
      vector_addr_o <= `IRQ_HW_VECTOR;
    end else begin
      irq_flag_rd_o <= irq_flag_next & irq_enable_next;
      vector_addr_o <= sw_irq_instr_i ? `IRQ_SW_VECTOR : `IRQ_HW_VECTOR;
    end
  end

endmodule // mcu_interrupt_controller

`default_nettype wire

// >>> hdl/irq_ctrl_regs.vh
// Constants for the interrupt controller: bit positions, vectors, reset values
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH

// Flag and enable register bit positions (11 hardware sources)
`define IRQ_NUM_SRC        11
`define IRQ_BIT_TIMER0     0
`define IRQ_BIT_TIMER1     1
`define IRQ_BIT_TIMER2     2
`define IRQ_BIT_TIMER3     3
`define IRQ_BIT_PINCHG     4
`define IRQ_BIT_EXT0       5
`define IRQ_BIT_WDOG       6
`define IRQ_BIT_EXT1       7
`define IRQ_BIT_LVD        8
`define IRQ_BIT_CMP        9
`define IRQ_BIT_CONV       10

// Fetch vectors
`define IRQ_PC_WIDTH       11
`define IRQ_SW_VECTOR      11'h001
`define IRQ_HW_VECTOR      11'h008

// Reset values
`define IRQ_FLAG_RESET     11'h000
`define IRQ_EN_RESET       11'h000
`define IRQ_GIE_RESET      1'b0

// Pin widths
`define IRQ_PORTA_WIDTH    8
`define IRQ_PORTB_WIDTH    6

`endif

// >>> hdl/edge_event_detect.v
// Single-input edge detector producing one-cycle event pulses
`timescale 1ns/1ps
`default_nettype none

module edge_event_detect (
  // Clock and reset
  input  wire clk_sys_i,
  input  wire resetn_i,
  // Sampled level
  input  wire level_i,
  // Event pulses
  output wire rise_o,
  output wire fall_o
);

  reg level_reg; // Previous sample

  // Previous-sample register; starts low so a high pin at reset gives a rise
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= level_i;
    end
  end

  assign rise_o = level_i & ~level_reg;
  assign fall_o = ~level_i & level_reg;

endmodule // edge_event_detect

`default_nettype wire

// >>> hdl/pin_change_detect.v
// Port A/B level change detector with wake enables and external-pin masking
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.vh"

module pin_change_detect (
  // Clock and reset
  input  wire                          clk_sys_i,
  input  wire                          resetn_i,
  // Pins and configuration
  input  wire [`IRQ_PORTA_WIDTH-1:0]   porta_pins_i,
  input  wire [`IRQ_PORTB_WIDTH-1:0]   portb_pins_i,
  input  wire [`IRQ_PORTA_WIDTH-1:0]   porta_is_input_i,
  input  wire [`IRQ_PORTB_WIDTH-1:0]   portb_is_input_i,
  input  wire [`IRQ_PORTA_WIDTH-1:0]   porta_wake_en_i,
  input  wire [`IRQ_PORTB_WIDTH-1:0]   portb_wake_en_i,
  input  wire                          ext_zero_select_i,
  input  wire                          ext_one_select_i,
  // Event
  output wire                          change_o
);

  reg  [`IRQ_PORTA_WIDTH-1:0] porta_reg;   // Previous port A levels
  reg  [`IRQ_PORTB_WIDTH-1:0] portb_reg;   // Previous port B levels
  wire [`IRQ_PORTB_WIDTH-1:0] portb_mask;  // Port B pins allowed to report

  // Sample history for both ports
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      porta_reg <= 8'h00;
      portb_reg <= 6'h00;
    end else begin
      porta_reg <= porta_pins_i;
      portb_reg <= portb_pins_i;
    end
  end

  // External select takes pins 0 and 1 away from level-change detection
  assign portb_mask = portb_is_input_i & portb_wake_en_i &
                      {4'hf, ~ext_one_select_i, ~ext_zero_select_i};

  assign change_o = |((porta_pins_i ^ porta_reg) & porta_is_input_i & porta_wake_en_i) |
                    |((portb_pins_i ^ portb_reg) & portb_mask);

endmodule // pin_change_detect

`default_nettype wire

// >>> verif/irq_checker.sv
// Checker: port-level timing properties of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module irq_checker (
  // Clock, reset, strobes and events
  input wire logic        clk_sys_i, resetn_i, sw_irq_instr_i, enable_irq_instr_i,
  input wire logic        disable_irq_instr_i, return_from_irq_instr_i, fetch_ready_i,
  input wire logic        flag_wr_i, enable_wr_i, timer_zero_wrap_i, timer_one_underflow_i,
  input wire logic        timer_two_underflow_i, timer_three_underflow_i, watchdog_expire_i,
  input wire logic        watchdog_irq_mode_i, conv_end_i, ext_zero_select_i, ext_edge_polarity_i,
  input wire logic [5:0]  portb_pins_i,
  // Outputs under watch
  input wire logic [10:0] irq_flag_rd_o, irq_enable_reg_o, vector_addr_o,
  input wire logic        global_irq_enable_o, vector_take_o, in_service_o
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Enabled pulse events at their flag positions; watchdog counts only in interrupt mode
  wire [10:0] ev_en = irq_enable_reg_o & {conv_end_i, 3'b000,
    watchdog_expire_i & watchdog_irq_mode_i, 2'b00, timer_three_underflow_i,
    timer_two_underflow_i, timer_one_underflow_i, timer_zero_wrap_i};
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // A redirect wins over the instruction strobes; they are kept out of the antecedents
  // A software strobe only redirects once the sequencer is ready for it
  sequence sw_req_s;
    sw_irq_instr_i && fetch_ready_i && !enable_irq_instr_i && !return_from_irq_instr_i;
  endsequence
  sequence sw_done_s; vector_addr_o == 11'h001 && !global_irq_enable_o; endsequence
  sequence hw_take_s;
    vector_take_o && !sw_irq_instr_i && !enable_irq_instr_i && !return_from_irq_instr_i;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sw_vector_a: assert property (sw_req_s |-> vector_take_o ##1 sw_done_s)
    else $error("software interrupt did not redirect to its vector");
  sw_wait_a: assert property (sw_irq_instr_i && !fetch_ready_i |-> !vector_take_o)
    else $error("redirect taken before the sequencer was ready");
  gie_set_a: assert property (enable_irq_instr_i && !disable_irq_instr_i && !sw_irq_instr_i
    && !vector_take_o |=> global_irq_enable_o) else $error("enable instruction ignored");
  gie_clear_a: assert property (disable_irq_instr_i |=> !global_irq_enable_o)
    else $error("disable instruction ignored");
  gie_return_a: assert property (return_from_irq_instr_i && !disable_irq_instr_i
    && !sw_irq_instr_i && !vector_take_o |=> global_irq_enable_o) else $error("return left gie low");
  hw_block_a: assert property (!global_irq_enable_o && !sw_irq_instr_i |-> !vector_take_o)
    else $error("redirect taken with gie low");
  hw_cause_a: assert property (vector_take_o && !sw_irq_instr_i |-> fetch_ready_i
    && irq_flag_rd_o != 11'h000 && vector_addr_o == 11'h008) else $error("bad hardware redirect");
  hw_clear_a: assert property (hw_take_s |=> !global_irq_enable_o && in_service_o)
    else $error("hardware redirect kept gie");
  flag_hold_a: assert property (!flag_wr_i && !enable_wr_i |=>
    (irq_flag_rd_o & $past(irq_flag_rd_o)) == $past(irq_flag_rd_o)) else $error("flag lost");
  flag_mask_a: assert property ($stable(irq_enable_reg_o) |->
    (irq_flag_rd_o & ~irq_enable_reg_o) == 11'h000) else $error("disabled flag visible");
  event_set_a: assert property (ev_en != 11'h000 && !enable_wr_i |=>
    (irq_flag_rd_o & $past(ev_en)) == $past(ev_en)) else $error("pulse event not flagged");
  ext_zero_a: assert property (ext_zero_select_i && ext_edge_polarity_i
    && $rose(portb_pins_i[0]) && irq_enable_reg_o[5] && !enable_wr_i |-> ##[1:3] irq_flag_rd_o[5])
    else $error("external zero edge not flagged");
endmodule // irq_checker
bind mcu_interrupt_controller irq_checker irq_checker_i (.clk_sys_i, .resetn_i, .sw_irq_instr_i,
  .enable_irq_instr_i, .disable_irq_instr_i, .return_from_irq_instr_i, .fetch_ready_i, .flag_wr_i,
  .enable_wr_i, .timer_zero_wrap_i, .timer_one_underflow_i, .timer_two_underflow_i,
  .timer_three_underflow_i, .watchdog_expire_i, .watchdog_irq_mode_i, .conv_end_i,
  .ext_zero_select_i, .ext_edge_polarity_i, .portb_pins_i, .irq_flag_rd_o, .irq_enable_reg_o,
  .vector_addr_o, .global_irq_enable_o, .vector_take_o, .in_service_o);
`default_nettype wire

// >>> verif/fetch_model.sv
// Fetch sequencer model: stalls redirects and latches the lagging vector address
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // Controller side
  input  wire logic        vector_take_i,
  input  wire logic [10:0] vector_addr_i,
  input  wire logic        slow_i,
  output var  logic        fetch_ready_o,
  output var  logic        taken_o,
  output var  logic [10:0] taken_addr_o
);
  logic pend_reg;  // Redirect seen, address due next cycle
  // The address is registered behind the redirect, so it is taken one cycle later
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_reg      <= 1'b0;
      fetch_ready_o <= 1'b0;
      taken_o       <= 1'b0;
      taken_addr_o  <= 11'h000;
    end else begin
      pend_reg      <= vector_take_i;
      taken_o       <= pend_reg;
      taken_addr_o  <= pend_reg ? vector_addr_i : taken_addr_o;
      // Busy sequencer accepts a redirect in about one cycle of three
      fetch_ready_o <= slow_i ? (($urandom % 3) == 0) : 1'b1;
    end
  end
endmodule // fetch_model
`default_nettype wire

// >>> verif/mcu_interrupt_controller_bench.sv
// Self-checking bench: events, instructions, flag views and queued vectors
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.vh"
`define check_eq(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module mcu_interrupt_controller_bench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk_sys_i = 1'b0;   // 20 MHz
  logic        resetn_i  = 1'b0;
  logic [3:0]  instr     = 4'h0;   // {return, disable, enable, software}
  logic        flag_wr   = 1'b0;
  logic        enable_wr = 1'b0;
  logic        ctrl_rd   = 1'b0;   // Comparator control read
  logic        wd_mode   = 1'b1;   // Watchdog interrupts instead of resetting
  logic [10:0] wdata     = 11'h000; // Shared: the two writes never coincide
  logic [10:0] ev        = 11'h000; // Pulse sources at their flag positions
  logic [7:0]  pa        = 8'h00;
  logic [5:0]  pb        = 6'h00;
  logic [5:0]  pb_wake   = 6'h00;
  logic [7:0]  pa_wake   = 8'h00;
  logic [13:0] is_in     = 14'h3fff; // {port B, port A} input directions
  logic [2:0]  ext_cfg   = 3'b000; // {polarity, select one, select zero}
  logic        low_voltage_detect       = 1'b1;   // Supply good at release: no fall
  logic        cmp_out   = 1'b0;
  logic        slow      = 1'b0;
  logic [10:0] m, exp_addr;
  logic [10:0] exp_q[$];           // Expected vector addresses, oldest first
  wire         fetch_ready, taken, take, global_irq_enable, cmp_copy, in_svc;
  wire  [10:0] taken_addr, flag_rd, en_reg, vaddr;
  int          err_total = 0;
  int          samples_checked = 0;
  int          pulse_bits[6] = '{0, 1, 2, 3, 6, 10};
  always #25 clk_sys_i = ~clk_sys_i;
  mcu_interrupt_controller mcu_interrupt_controller_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .sw_irq_instr_i(instr[0]), .enable_irq_instr_i(instr[1]), .disable_irq_instr_i(instr[2]),
    .return_from_irq_instr_i(instr[3]), .fetch_ready_i(fetch_ready), .flag_wr_i(flag_wr),
    .flag_wdata_i(wdata), .enable_wr_i(enable_wr), .enable_wdata_i(wdata),
    .osc_comparator_ctrl_rd_i(ctrl_rd), .timer_zero_wrap_i(ev[0]), .timer_one_underflow_i(ev[1]),
    .timer_two_underflow_i(ev[2]), .timer_three_underflow_i(ev[3]), .watchdog_expire_i(ev[6]),
    .watchdog_irq_mode_i(wd_mode), .porta_pins_i(pa), .portb_pins_i(pb),
    .porta_is_input_i(is_in[7:0]), .portb_is_input_i(is_in[13:8]), .porta_wake_en_i(pa_wake),
    .portb_wake_en_i(pb_wake), .ext_zero_select_i(ext_cfg[0]), .ext_one_select_i(ext_cfg[1]),
    .ext_edge_polarity_i(ext_cfg[2]), .low_voltage_detect_i(low_voltage_detect), .comparator_out_i(cmp_out),
    .conv_end_i(ev[10]), .irq_flag_rd_o(flag_rd), .irq_enable_reg_o(en_reg),
    .global_irq_enable_o(global_irq_enable), .comparator_copy_o(cmp_copy), .vector_take_o(take),
    .vector_addr_o(vaddr), .in_service_o(in_svc));
  fetch_model fetch_model_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .vector_take_i(take),
    .vector_addr_i(vaddr), .slow_i(slow), .fetch_ready_o(fetch_ready), .taken_o(taken),
    .taken_addr_o(taken_addr));
  // ----------------------------------------
  // Drivers: one-cycle strobes (software held until ready), launched just after an edge
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic op(input logic [3:0] i, input logic [10:0] e);
    @(posedge clk_sys_i);
    instr <= i;
    ev    <= e;
    // A software strobe is held until the sequencer is ready to redirect
    do @(posedge clk_sys_i); while (i[0] && fetch_ready !== 1'b1);
    instr <= 4'h0;
    ev    <= 11'h000;
  endtask
  // Flag write ANDs (zero clears); otherwise the enable register loads
  task automatic wr(input logic f, input logic [10:0] v);
    @(posedge clk_sys_i);
    flag_wr   <= f;
    enable_wr <= !f;
    wdata     <= v;
    @(posedge clk_sys_i);
    flag_wr   <= 1'b0;
    enable_wr <= 1'b0;
  endtask
  // Leave an extra edge so pin detectors have landed before reading
  task automatic look();
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  // Bounded wait until the partner has reported every queued redirect
  task automatic drain();
    for (int n = 0; n < 100 && exp_q.size() != 0; n++) @(posedge clk_sys_i);
    `check_eq(exp_q.size(), 0)
  endtask
  task automatic complete_run();
    if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Monitor: every redirect pops the oldest note; 7ff marks one nobody expected
  always @(posedge clk_sys_i) begin
    if (taken === 1'b1) begin
      exp_addr = (exp_q.size() != 0) ? exp_q.pop_front() : 11'h7ff;
      `check_eq(taken_addr, exp_addr)
    end
  end
  // Watchdog: the whole run needs a few hundred cycles
  initial begin
    tick(20000);
    err_total++;
    complete_run();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(63900));
    tick(10);
    resetn_i <= 1'b1;
    look();
    `check_eq({global_irq_enable, flag_rd, vaddr}, {1'b0, 11'h000, `IRQ_HW_VECTOR})
    // Pulse sources latch while hidden, show once enabled, clear only on zero
    foreach (pulse_bits[i]) begin
      m = 11'h001 << pulse_bits[i];
      op(4'h0, m);
      look();
      `check_eq(flag_rd, 11'h000)
      wr(1'b0, m);
      look();
      `check_eq({en_reg, flag_rd}, {m, m})
      wr(1'b1, ~m);
      look();
      `check_eq(flag_rd, 11'h000)
    end
    wr(1'b0, 11'h040);
    wd_mode <= 1'b0;
    op(4'h0, 11'h040);
    look();
    `check_eq(flag_rd, 11'h000)
    // Pin change on random port bits; external pins then use edges instead
    wr(1'b0, 11'h3b0);
    pa_wake <= 8'hff;
    pb_wake <= 6'h3f;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys_i);
      if (k[0]) pb <= pb ^ (6'h04 << ($urandom % 4));
      else pa <= pa ^ (8'h01 << ($urandom % 8));
      look();
      `check_eq(flag_rd, 11'h010)
      wr(1'b1, 11'h000);
    end
    // Pins turned to outputs must not report a level change
    is_in <= 14'h0000;
    @(posedge clk_sys_i);
    pa <= ~pa;
    pb <= pb ^ 6'h3c;
    look();
    `check_eq(flag_rd, 11'h000)
    @(posedge clk_sys_i);
    is_in   <= 14'h3fff;
    ext_cfg <= 3'b111;
    @(posedge clk_sys_i);
    pb[0] <= 1'b1;
    look();
    `check_eq(flag_rd, 11'h020)
    wr(1'b1, 11'h000);
    pb[1] <= 1'b1;
    look();
    `check_eq(flag_rd, 11'h080)
    wr(1'b1, 11'h000);
    ext_cfg <= 3'b011;
    @(posedge clk_sys_i);
    pb[1:0] <= 2'b00;
    low_voltage_detect     <= 1'b0;
    look();
    `check_eq(flag_rd, 11'h1a0)
    // Comparator mismatch re-sets the flag until a control read resyncs the copy
    wr(1'b1, 11'h000);
    cmp_out <= 1'b1;
    look();
    wr(1'b1, 11'h000);
    look();
    `check_eq(flag_rd, 11'h200)
    @(posedge clk_sys_i);
    ctrl_rd <= 1'b1;
    @(posedge clk_sys_i);
    ctrl_rd <= 1'b0;
    wr(1'b1, 11'h000);
    look();
    `check_eq({cmp_copy, flag_rd}, {1'b1, 11'h000})
    // Hardware redirect waits for the enable; nesting re-enables in the handler
    wr(1'b0, 11'h7ff);
    slow <= 1'b1;
    op(4'h0, 11'h001);
    tick(8);
    exp_q.push_back(`IRQ_HW_VECTOR);
    op(4'h2, 11'h000);
    drain();
    `check_eq({global_irq_enable, in_svc}, 2'b01)
    exp_q.push_back(`IRQ_HW_VECTOR);
    op(4'h2, 11'h402);
    drain();
    look();
    `check_eq(flag_rd, 11'h403)
    // A return with a flag still pending redirects again; the final handler clears its flags first, never enabling right before a return
    wr(1'b1, 11'h000);
    op(4'h8, 11'h000);
    look();
    `check_eq(global_irq_enable, 1'b1)
    exp_q.push_back(`IRQ_SW_VECTOR);
    op(4'h1, 11'h000);
    drain();
    `check_eq(global_irq_enable, 1'b0)
    op(4'h8, 11'h000);
    op(4'h6, 11'h000);
    look();
    `check_eq(global_irq_enable, 1'b0)
    exp_q.push_back(`IRQ_SW_VECTOR);
    op(4'h1, 11'h008);
    drain();
    tick(8);
    exp_q.push_back(`IRQ_HW_VECTOR);
    op(4'h8, 11'h000);
    drain();
    wr(1'b1, 11'h000);
    op(4'h8, 11'h000);
    tick(8);
    `check_eq({global_irq_enable, exp_q.size()}, {1'b1, 32'd0})
    complete_run();
  end
endmodule // mcu_interrupt_controller_bench
`default_nettype wire
